// *** rtl/coil_cmd_pkg.sv ***
// Constants for the press program coil command interpreter.
// Assumes a byte receiver and transmitter on the same 25 MHz clock.

package coil_cmd_pkg;

   localparam logic [7:0]  FUNC_WRITE_COIL  = 8'h05;
   localparam logic [7:0]  BROADCAST_ADDR   = 8'h00;
   localparam logic [15:0] FINISH_COIL_ADDR = 16'h049e;
   localparam logic [15:0] LAUNCH_COIL_ADDR = 16'h049f;
   localparam logic [15:0] COIL_ON          = 16'hff00;
   localparam logic [15:0] COIL_OFF         = 16'h0000;

   localparam int          FRAME_BYTES = 8;
   localparam logic [3:0]  FRAME_LEN   = 4'h8;
   localparam logic [3:0]  FRAME_OVER  = 4'h9;

   localparam logic [15:0] CRC_INIT = 16'hffff;
   localparam logic [15:0] CRC_POLY = 16'ha001;

   localparam int CLK_MHZ        = 25;
   localparam int SILENT_TIME_US = 1750;
   localparam int SILENT_CYCLES  = SILENT_TIME_US * CLK_MHZ;

   localparam logic        COIL_RESET  = 1'b0;
   localparam logic [15:0] NUMBER_RESET = 16'h0000;

   typedef enum logic [1:0] {
      ST_RECV  = 2'b01,
      ST_REPLY = 2'b10
   } state_t;

endpackage : coil_cmd_pkg

// *** rtl/coil_cmd.sv ***
// Slave interpreter for the forced finish and launch coils.
// Assumes rx bytes and tx handshake come from a UART on clk.

`timescale 1ns/1ns
`default_nettype none

////////////////////////////////////////////////////////////////////

module coil_cmd
   import coil_cmd_pkg::*;
#(
   parameter int SILENT_LEN = SILENT_CYCLES
) (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic [3:0]  axis_number,
   input  wire logic [15:0] program_number_command,
   input  wire logic        rx_valid,
   input  wire logic [7:0]  rx_byte,
   output logic             tx_valid,
   output logic [7:0]       tx_byte,
   input  wire logic        tx_ready,
   output logic             forced_program_finish,
   output logic             press_program_launch,
   output logic [15:0]      launch_number,
   output logic             launch_refused,
   output logic             finish_coil,
   output logic             launch_coil
);

   localparam int GAP_W = $clog2(SILENT_LEN + 1);
   localparam logic [GAP_W-1:0] GAP_LAST = GAP_W'(SILENT_LEN - 1);

   ////////////////////////////////////////////////////////////////

   state_t            state_reg,  state_next;
   logic [7:0]        frame_reg  [FRAME_BYTES];
   logic [7:0]        frame_next [FRAME_BYTES];
   logic [3:0]        count_reg,  count_next;
   logic [15:0]       crc_reg,    crc_next;
   logic [GAP_W-1:0]  gap_reg,    gap_next;
   logic              quiet_reg,  quiet_next;
   logic              bad_reg,    bad_next;
   logic [2:0]        idx_reg,    idx_next;
   logic [7:0]        txb_reg,    txb_next;
   logic              fin_reg,    fin_next;
   logic              lau_reg,    lau_next;
   logic              finp_reg,   finp_next;
   logic              laup_reg,   laup_next;
   logic              refp_reg,   refp_next;
   logic [15:0]       num_reg,    num_next;

   logic [7:0]  f_addr;
   logic [7:0]  f_func;
   logic [15:0] f_coil;
   logic [15:0] f_data;
   logic [7:0]  own_addr;
   logic        frame_end;
   logic        good;
   logic        for_us;
   logic        known;
   logic        act;

   // One byte of the reflected CRC-16 with polynomial a001.
   function automatic logic [15:0] crc_step(
      input logic [15:0] c,
      input logic [7:0]  b
   );
      logic [15:0] r;
      r = c ^ {8'h00, b};
      for (int i = 0; i < 8; i++) begin
         r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
      end
      return r;
   endfunction : crc_step

   ////////////////////////////////////////////////////////////////

   assign f_addr   = frame_reg[0];
   assign f_func   = frame_reg[1];
   assign f_coil   = {frame_reg[2], frame_reg[3]};
   assign f_data   = {frame_reg[4], frame_reg[5]};
   assign own_addr = {4'h0, axis_number} + 8'h01;

   // The frame closes once the line has stayed silent long enough.
   assign frame_end = (state_reg == ST_RECV) && !rx_valid
                      && (count_reg != 4'h0)
                      && (gap_reg == GAP_LAST);

   // Running the CRC over the check bytes too leaves zero if intact.
   assign good = (count_reg == FRAME_LEN) && !bad_reg
                 && (crc_reg == 16'h0000);

   assign for_us = (f_addr == own_addr)
                   || (f_addr == BROADCAST_ADDR);

   // Anything else is dropped silently, no exception frame.
   assign known = (f_func == FUNC_WRITE_COIL)
                  && ((f_coil == FINISH_COIL_ADDR)
                      || (f_coil == LAUNCH_COIL_ADDR))
                  && ((f_data == COIL_ON)
                      || (f_data == COIL_OFF));

   assign act = frame_end && good && for_us && known;

   ////////////////////////////////////////////////////////////////

   always_comb begin
      state_next = state_reg;
      frame_next = frame_reg;
      count_next = count_reg;
      crc_next   = crc_reg;
      gap_next   = gap_reg;
      quiet_next = quiet_reg;
      bad_next   = bad_reg;
      idx_next   = idx_reg;
      txb_next   = txb_reg;
      fin_next   = fin_reg;
      lau_next   = lau_reg;
      finp_next  = 1'b0;
      laup_next  = 1'b0;
      refp_next  = 1'b0;
      num_next   = num_reg;

      unique case (state_reg)
         ST_RECV: begin
            if (rx_valid) begin
               gap_next = '0;
               crc_next = crc_step(crc_reg, rx_byte);
               // A frame must follow a silent interval.
               if (!quiet_reg) begin
                  bad_next = 1'b1;
               end
               if (count_reg < FRAME_LEN) begin
                  frame_next[count_reg[2:0]] = rx_byte;
                  count_next = count_reg + 4'h1;
               end else begin
                  count_next = FRAME_OVER;
               end
            end else if (gap_reg != GAP_LAST) begin
               gap_next = gap_reg + GAP_W'(1);
            end else begin
               quiet_next = 1'b1;
            end

            if (frame_end) begin
               count_next = 4'h0;
               crc_next   = CRC_INIT;
               bad_next   = 1'b0;
            end

            if (act && (f_coil == FINISH_COIL_ADDR)) begin
               fin_next = (f_data == COIL_ON);
               if (!fin_reg && (f_data == COIL_ON)) begin
                  finp_next = 1'b1;
               end
            end

            if (act && (f_coil == LAUNCH_COIL_ADDR)) begin
               lau_next = (f_data == COIL_ON);
               if (!lau_reg && (f_data == COIL_ON)) begin
                  if (fin_reg) begin
                     refp_next = 1'b1;
                  end else begin
                     laup_next = 1'b1;
                     num_next  = program_number_command;
                  end
               end
            end

            if (act && (f_addr != BROADCAST_ADDR)) begin
               state_next = ST_REPLY;
               idx_next   = 3'h0;
               txb_next   = frame_reg[0];
            end
         end

         ST_REPLY: begin
            if (tx_ready) begin
               if (idx_reg == 3'h7) begin
                  state_next = ST_RECV;
                  gap_next   = '0;
               end else begin
                  idx_next = idx_reg + 3'h1;
                  txb_next = frame_reg[idx_reg + 3'h1];
               end
            end
         end

         default: begin
            state_next = ST_RECV;
         end
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_reg <= ST_RECV;
         for (int i = 0; i < FRAME_BYTES; i++) begin
            frame_reg[i] <= 8'h00;
         end
         count_reg <= 4'h0;
         crc_reg   <= CRC_INIT;
         gap_reg   <= '0;
         quiet_reg <= 1'b0;
         bad_reg   <= 1'b0;
         idx_reg   <= 3'h0;
         txb_reg   <= 8'h00;
         fin_reg   <= COIL_RESET;
         lau_reg   <= COIL_RESET;
         finp_reg  <= 1'b0;
         laup_reg  <= 1'b0;
         refp_reg  <= 1'b0;
         num_reg   <= NUMBER_RESET;
      end else begin
         state_reg <= state_next;
         frame_reg <= frame_next;
         count_reg <= count_next;
         crc_reg   <= crc_next;
         gap_reg   <= gap_next;
         quiet_reg <= quiet_next;
         bad_reg   <= bad_next;
         idx_reg   <= idx_next;
         txb_reg   <= txb_next;
         fin_reg   <= fin_next;
         lau_reg   <= lau_next;
         finp_reg  <= finp_next;
         laup_reg  <= laup_next;
         refp_reg  <= refp_next;
         num_reg   <= num_next;
      end
   end

   ////////////////////////////////////////////////////////////////

   assign tx_valid              = (state_reg == ST_REPLY);
   assign tx_byte               = txb_reg;
   assign forced_program_finish = finp_reg;
   assign press_program_launch  = laup_reg;
   assign launch_number         = num_reg;
   assign launch_refused        = refp_reg;
   assign finish_coil           = fin_reg;
   assign launch_coil           = lau_reg;

   ////////////////////////////////////////////////////////////////

   AST_FINISH_EDGE: assert property (
      @(posedge clk) disable iff (rst)
      finp_reg |-> fin_reg && !$past(fin_reg)
                   && ($past(f_data) == COIL_ON))
      else $error("finish pulse without an OFF to ON edge");

   AST_LAUNCH_BLOCKED: assert property (
      @(posedge clk) disable iff (rst)
      fin_reg && $stable(fin_reg) |-> !laup_reg)
      else $error("launch accepted while finish coil is ON");

   AST_FINISH_ADDR: assert property (
      @(posedge clk) disable iff (rst)
      finp_reg |-> ($past(f_coil) == FINISH_COIL_ADDR)
                   && ($past(f_func) == FUNC_WRITE_COIL))
      else $error("finish pulse from a wrong coil or function");

   AST_LAUNCH_NUMBER: assert property (
      @(posedge clk) disable iff (rst)
      laup_reg |-> num_reg == $past(program_number_command))
      else $error("launch number is not the commanded one");

   AST_LAUNCH_ADDR: assert property (
      @(posedge clk) disable iff (rst)
      laup_reg |-> ($past(f_coil) == LAUNCH_COIL_ADDR)
                   && ($past(f_data) == COIL_ON))
      else $error("launch pulse from a wrong coil or data");

   AST_CRC_CHECKED: assert property (
      @(posedge clk) disable iff (rst)
      (finp_reg || laup_reg) |-> ($past(crc_reg) == 16'h0000)
                                 && ($past(count_reg) == FRAME_LEN))
      else $error("action taken on a bad CRC or length");

   AST_ECHO_FIRST: assert property (
      @(posedge clk) disable iff (rst)
      $rose(tx_valid) |-> tx_byte == frame_reg[0])
      else $error("echo does not start with the query address");

   AST_ECHO_HOLD: assert property (
      @(posedge clk) disable iff (rst)
      tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte))
      else $error("reply byte changed before it was taken");

   AST_BAD_IGNORED: assert property (
      @(posedge clk) disable iff (rst)
      frame_end && !known |=> !(finp_reg || laup_reg || refp_reg || tx_valid))
      else $error("action or reply on an invalid query");

   AST_SILENCE: assert property (
      @(posedge clk) disable iff (rst)
      $rose(tx_valid) |-> $past(gap_reg) == GAP_LAST)
      else $error("reply started before the silent interval");

   AST_NO_BCAST_REPLY: assert property (
      @(posedge clk) disable iff (rst)
      tx_valid |-> f_addr == own_addr)
      else $error("reply sent for a foreign or broadcast frame");

endmodule : coil_cmd

`default_nettype wire

// *** test/coil_master.sv ***
// Behavioural link master that sends write-single-coil frames and takes replies.
// Assumes the slave sits on the same clock and samples on the rising edge.
`timescale 1ns/1ns
`default_nettype none
module coil_master
   import coil_cmd_pkg::*;
(
   input  wire logic       clk,
   output logic            rx_valid,
   output logic [7:0]      rx_byte,
   output logic            tx_ready
);
   logic [7:0] sent [$];
   initial begin
      rx_valid = 1'b0;
      rx_byte  = 8'h00;
      tx_ready = 1'b0;
   end
   // Alternating ready makes the reply path see both stalls and prompt takes.
   always @(negedge clk) tx_ready <= ~tx_ready;
   ////////////////////////////////////////////////////////////////////
   function automatic logic [15:0] crc16(input logic [7:0] f [$]);
      logic [15:0] c;
      c = CRC_INIT;
      foreach (f[i]) begin
         c ^= {8'h00, f[i]};
         for (int k = 0; k < 8; k++) c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
      end
      return c;
   endfunction : crc16
   task automatic send(input logic [7:0] adr, input logic [7:0] fn, input logic [15:0] coil,
                       input logic [15:0] data, input int len, input logic bad, input int gap);
      logic [15:0] c;
      sent = {adr, fn, coil[15:8], coil[7:0], data[15:8], data[7:0]};
      c = crc16(sent) ^ {15'h0000, bad};
      sent.push_back(c[7:0]);
      sent.push_back(c[15:8]);
      for (int i = 0; i < len; i++) begin
         @(negedge clk);
         rx_valid = 1'b1;
         rx_byte  = sent[i % FRAME_BYTES];
         @(negedge clk);
         rx_valid = 1'b0;
         rx_byte  = ~sent[i % FRAME_BYTES];
         repeat (gap) @(negedge clk);
      end
   endtask : send
endmodule : coil_master
`default_nettype wire

// *** test/press_program_coil_commands_tb.sv ***
// Self-checking bench for the coil command interpreter.
// Assumes coil_master as link partner and a shortened silent interval.
`timescale 1ns/1ns
`default_nettype none
module press_program_coil_commands_tb;
   import coil_cmd_pkg::*;
   localparam int SIL = 40;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic [3:0]  axis_number = 4'h0;
   logic [15:0] program_number_command = 16'h0000;
   logic        rx_valid, tx_valid, tx_ready, fin, lau, refu, fcoil, lcoil;
   logic [7:0]  rx_byte, tx_byte, ad;
   logic [15:0] launch_number;
   int          seed = 71, bad_count = 0, comparisons = 0, cycles = 0, fin_n, lau_n, ref_n;
   logic [7:0]  echo [$];
   always #20 clk = ~clk;
   coil_cmd #(.SILENT_LEN(SIL)) u_dut (.clk(clk), .rst(rst), .axis_number(axis_number),
      .program_number_command(program_number_command), .rx_valid(rx_valid),
      .rx_byte(rx_byte), .tx_valid(tx_valid), .tx_byte(tx_byte), .tx_ready(tx_ready),
      .forced_program_finish(fin), .press_program_launch(lau), .launch_number(launch_number),
      .launch_refused(refu), .finish_coil(fcoil), .launch_coil(lcoil));
   coil_master u_master (.clk(clk), .rx_valid(rx_valid), .rx_byte(rx_byte), .tx_ready(tx_ready));
   ////////////////////////////////////////////////////////////////////
   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : wrap_up
   always @(posedge clk) begin
      cycles++;
      if (fin === 1'b1) fin_n++;
      if (lau === 1'b1) lau_n++;
      if (refu === 1'b1) ref_n++;
      if (tx_valid === 1'b1 && tx_ready === 1'b1) echo.push_back(tx_byte);
      if (cycles == 20000) begin
         bad_count++;
         wrap_up();
      end
   end
   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic frame(input logic [7:0] adr, input logic [7:0] fn, input logic [15:0] coil,
      input logic [15:0] data, input int len, input logic bad, input int e_fin, input int e_lau,
      input int e_ref, input logic e_rep);
      fin_n = 0;
      lau_n = 0;
      ref_n = 0;
      echo.delete();
      u_master.send(adr, fn, coil, data, len, bad, $random(seed) & 3);
      repeat (SIL + 40) @(negedge clk);
      check("finish pulses", e_fin[15:0], fin_n[15:0]);
      check("launch pulses", e_lau[15:0], lau_n[15:0]);
      check("refused pulses", e_ref[15:0], ref_n[15:0]);
      check("reply length", e_rep ? 16'h0008 : 16'h0000, 16'(echo.size()));
      foreach (echo[i]) check("reply byte", {8'h00, u_master.sent[i]}, {8'h00, echo[i]});
   endtask : frame
   ////////////////////////////////////////////////////////////////////
   initial begin
      repeat (5) @(negedge clk);
      rst = 1'b0;
      check("reset outs", 16'h0000,
            {2'b00, tx_valid, fcoil, lcoil, fin, lau, refu, tx_byte});
      check("reset number", NUMBER_RESET, launch_number);
      repeat (SIL + 5) @(negedge clk);
      frame(8'h01, FUNC_WRITE_COIL, FINISH_COIL_ADDR, COIL_OFF, 8, 0, 0, 0, 0, 1);
      frame(8'h01, FUNC_WRITE_COIL, FINISH_COIL_ADDR, COIL_ON, 8, 0, 1, 0, 0, 1);
      check("crc bytes", 16'hece4, {u_master.sent[6], u_master.sent[7]});
      check("finish coil", 16'h0001, {15'h0000, fcoil});
      frame(8'h01, FUNC_WRITE_COIL, FINISH_COIL_ADDR, COIL_ON, 8, 0, 0, 0, 0, 1);
      frame(8'h01, FUNC_WRITE_COIL, LAUNCH_COIL_ADDR, COIL_OFF, 8, 0, 0, 0, 0, 1);
      frame(8'h01, FUNC_WRITE_COIL, LAUNCH_COIL_ADDR, COIL_ON, 8, 0, 0, 0, 1, 1);
      frame(8'h01, FUNC_WRITE_COIL, FINISH_COIL_ADDR, COIL_OFF, 8, 0, 0, 0, 0, 1);
      for (int i = 0; i < 6; i++) begin
         axis_number = 4'($random(seed));
         program_number_command = 16'($random(seed));
         ad = {4'h0, axis_number} + 8'h01;
         frame(ad, FUNC_WRITE_COIL, LAUNCH_COIL_ADDR, COIL_OFF, 8, 0, 0, 0, 0, 1);
         frame(ad, FUNC_WRITE_COIL, LAUNCH_COIL_ADDR, COIL_ON, 8, 0, 0, 1, 0, 1);
         check("launch number", program_number_command, launch_number);
         check("launch coil", 16'h0001, {15'h0000, lcoil});
      end
      frame(ad + 8'h01, FUNC_WRITE_COIL, FINISH_COIL_ADDR, COIL_ON, 8, 0, 0, 0, 0, 0);
      frame(ad, 8'h06, FINISH_COIL_ADDR, COIL_ON, 8, 0, 0, 0, 0, 0);
      frame(ad, FUNC_WRITE_COIL, 16'h049d, COIL_ON, 8, 0, 0, 0, 0, 0);
      frame(ad, FUNC_WRITE_COIL, FINISH_COIL_ADDR, 16'h1234, 8, 0, 0, 0, 0, 0);
      frame(ad, FUNC_WRITE_COIL, FINISH_COIL_ADDR, COIL_ON, 7, 0, 0, 0, 0, 0);
      frame(ad, FUNC_WRITE_COIL, FINISH_COIL_ADDR, COIL_ON, 8, 1, 0, 0, 0, 0);
      frame(ad, FUNC_WRITE_COIL, FINISH_COIL_ADDR, COIL_ON, 9, 0, 0, 0, 0, 0);
      check("finish coil", 16'h0000, {15'h0000, fcoil});
      frame(BROADCAST_ADDR, FUNC_WRITE_COIL, FINISH_COIL_ADDR, COIL_ON, 8, 0, 1, 0, 0, 0);
      check("finish coil", 16'h0001, {15'h0000, fcoil});
      // A second reset: a frame sent before the line has been silent must be dropped.
      rst = 1'b1;
      repeat (5) @(negedge clk);
      rst = 1'b0;
      check("reset outs", 16'h0000,
            {2'b00, tx_valid, fcoil, lcoil, fin, lau, refu, tx_byte});
      check("reset number", NUMBER_RESET, launch_number);
      frame(ad, FUNC_WRITE_COIL, FINISH_COIL_ADDR, COIL_ON, 8, 0, 0, 0, 0, 0);
      frame(ad, FUNC_WRITE_COIL, FINISH_COIL_ADDR, COIL_ON, 8, 0, 1, 0, 0, 1);
      wrap_up();
   end
endmodule : press_program_coil_commands_tb
`default_nettype wire
